// file: ufrh_consts.vh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef UFRH_CONSTS_VH
`define UFRH_CONSTS_VH

// Byte offsets of the registers on the APB window.
`define UFRH_OFF_INTERVAL   8'h34
`define UFRH_OFF_COUNTDOWN  8'h38
`define UFRH_OFF_FRAMENUM   8'h3C
`define UFRH_OFF_PERIODIC   8'h40
`define UFRH_OFF_LSCUT      8'h44
`define UFRH_OFF_DESC_A     8'h48
`define UFRH_OFF_DESC_B     8'h4C

// Field positions inside the frame interval register.
`define UFRH_FI_MSB         13
`define UFRH_LPB_LSB        16
`define UFRH_LPB_MSB        30
`define UFRH_TOGGLE_BIT     31

// Field positions inside descriptor A.
`define UFRH_PCNT_MSB       7
`define UFRH_PGRP_BIT       8
`define UFRH_APWR_BIT       9
`define UFRH_DTYP_BIT       10
`define UFRH_OCGRP_BIT      11
`define UFRH_OCABS_BIT      12
`define UFRH_PSW_LSB        24
`define UFRH_PSW_MSB        31

// Field positions inside descriptor B.
`define UFRH_RMV_MSB        3
`define UFRH_PPM_LSB        16
`define UFRH_PPM_MSB        19

// Field widths of the shorter registers.
`define UFRH_PS_MSB         13
`define UFRH_LST_MSB        11
`define UFRH_FN_MSB         15

// Reset values.
`define UFRH_RST_INTERVAL   14'h2EDF
`define UFRH_RST_LPB        15'h0000
`define UFRH_RST_PERIODIC   14'h0000
`define UFRH_RST_LSCUT      12'h628
`define UFRH_RST_PGRP       1'h1
`define UFRH_RST_APWR       1'h0
`define UFRH_RST_OCGRP      1'h1
`define UFRH_RST_OCABS      1'h0
`define UFRH_RST_PSW        8'h0F
`define UFRH_RST_RMV        3'h0

// Bit time: the clock rate and the full-speed bit rate in MHz.
`define UFRH_CLK_MHZ        200
`define UFRH_BIT_MHZ        12
// Edges after reset release before the edge at which the straps are caught.
`define UFRH_STRAP_WAIT     2'h2

`endif

// file: ufrh_frame_timer.v
// Frame countdown, toggle copy and frame number counter.
`timescale 1ns/1ps
`include "ufrh_consts.vh"

module ufrh_frame_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        soft_clr,
    input  wire        run,
    input  wire [13:0] interval,
    input  wire        int_toggle,
    output reg  [13:0] countdown_q,
    output reg         cd_toggle_q,
    output reg  [15:0] frame_count_q,
    output reg         frame_start_q
);
    localparam [7:0] ACC_ADD = `UFRH_BIT_MHZ;
    localparam [7:0] ACC_MOD = `UFRH_CLK_MHZ;

    reg  [7:0] acc_q;
    wire [7:0] acc_sum;
    wire       bit_tick;

    // A phase accumulator gives an even average of 12 ticks per 200 edges,
    // since 200 MHz holds no whole number of bit times.
    assign acc_sum  = acc_q + ACC_ADD;
    assign bit_tick = run && (acc_sum >= ACC_MOD);

    // One count per bit time; at zero, reload and open a new frame.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q         <= 8'h00;
            countdown_q   <= `UFRH_RST_INTERVAL;
            cd_toggle_q   <= 1'b0;
            frame_count_q <= 16'h0000;
            frame_start_q <= 1'b0;
        end else if (soft_clr) begin
            acc_q         <= 8'h00;
            countdown_q   <= `UFRH_RST_INTERVAL;
            cd_toggle_q   <= 1'b0;
            frame_count_q <= 16'h0000;
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= 1'b0;
            if (!run) begin
                acc_q <= 8'h00;
            end else if (bit_tick) begin
                acc_q <= acc_sum - ACC_MOD;
            end else begin
                acc_q <= acc_sum;
            end
            if (bit_tick) begin
                if (countdown_q == 14'h0000) begin
                    countdown_q   <= interval;
                    cd_toggle_q   <= int_toggle;
                    frame_count_q <= frame_count_q + 16'h0001;
                    frame_start_q <= 1'b1;
                end else begin
                    countdown_q <= countdown_q - 14'h0001;
                end
            end
        end
    end

endmodule

// file: ufrh_top.v
// Frame timing and root hub descriptor registers behind an APB slave.
//
// How it works
// - Writable 14-bit frame interval, reset 2EDFh.
// - Writable 15-bit largest packet field, reset zero.
// - Read-only 14-bit bit-time countdown, reset 2EDFh.
// - At zero, copy interval toggle to countdown toggle.
// - Frame number increments on every reload.
// - Periodic start value opens periodic service.
// - Low-speed cutoff decides late low-speed starts.
// - Port count follows port configuration strap.
// - Power grouping bit, reset one.
// - Always-powered bit, reset zero.
// - Device type bit always reads zero.
// - Overcurrent grouping bit, reset one.
// - Overcurrent-absent bit, reset zero.
// - Writable power settle wait, reset 0Fh.
// - Descriptor fields reset only by hardware reset.
// - Removable flags: bit0 reserved, bits1-3 ports.
// - Port power masks: bit0 reserved, bits1-3 ports.
// - Reserved bits read zero, ignore writes.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "ufrh_consts.vh"

module ufrh_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        soft_reset,
    input  wire        frame_run,
    input  wire [2:0]  port_config_register,
    input  wire        second_function,
    output reg         sof_q,
    output reg         periodic_active_q,
    output reg         low_speed_ok_q,
    output reg  [7:0]  port_count_q,
    output reg         power_grouping_select_q,
    output reg         always_powered_q,
    output reg         overcurrent_grouping_q,
    output reg         overcurrent_absent_q,
    output reg  [3:0]  removable_flags_q,
    output reg  [3:0]  port_power_masks_q
);

    // Port count for a strap setting; the second function has one port fewer at settings 5 and 3.
    function [7:0] port_count_of;
        input [2:0] cfg;
        input       func2;
        begin
            case (cfg)
                3'h5:    port_count_of = func2 ? 8'h02 : 8'h03;
                3'h4:    port_count_of = 8'h02;
                3'h3:    port_count_of = func2 ? 8'h01 : 8'h02;
                default: port_count_of = 8'h01;
            endcase
        end
    endfunction

    // Default port power masks for a strap setting, ports 3 down to 1.
    function [2:0] mask_default_of;
        input [2:0] cfg;
        input       func2;
        begin
            case (cfg)
                3'h5:    mask_default_of = func2 ? 3'h3 : 3'h7;
                3'h4:    mask_default_of = 3'h3;
                3'h3:    mask_default_of = func2 ? 3'h1 : 3'h3;
                default: mask_default_of = 3'h1;
            endcase
        end
    endfunction

    // Register decode, used by both the read path and the write strobes.
    function addr_is;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_is = (addr == offset);
        end
    endfunction

    // Frame timing registers.
    reg  [13:0] frame_interval_q;
    reg  [14:0] largest_packet_bits_q;
    reg         interval_toggle_q;
    reg  [13:0] periodic_start_value_q;
    reg  [11:0] low_speed_cutoff_q;

    // Descriptor registers (hardware reset only).
    reg  [7:0]  power_settle_wait_q;
    reg  [2:0]  removable_q;
    reg  [2:0]  mask_q;

    // Strap synchronisers and capture sequencing.
    reg  [3:0]  strap_s1_q;
    reg  [3:0]  strap_s2_q;
    reg  [1:0]  strap_wait_q;

    // Frame timer outputs.
    wire [13:0] countdown_value;
    wire        countdown_toggle;
    wire [15:0] frame_count;
    wire        frame_start;

    // Bus decode.
    wire        access;
    wire        wr_en;
    reg         hit_d;
    reg  [31:0] rdata_d;

    // The strap pins come from another domain: two flops before use.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_q <= 4'h0;
            strap_s2_q <= 4'h0;
        end else begin
            strap_s1_q <= {second_function, port_config_register};
            strap_s2_q <= strap_s1_q;
        end
    end

    // Waits for the synchronised strap after release, then stops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_wait_q <= 2'h0;
        end else if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
        end
    end

    // The access phase takes two cycles so that every answer is registered.
    assign access = psel && penable;
    assign wr_en  = access && pwrite && pready;

    // Read mux; unmapped offsets answer zero with an error.
    always @* begin
        hit_d   = 1'b1;
        rdata_d = 32'h0000_0000;
        if (addr_is(paddr, `UFRH_OFF_INTERVAL)) begin
            rdata_d[`UFRH_FI_MSB:0] = frame_interval_q;
            rdata_d[`UFRH_LPB_MSB:`UFRH_LPB_LSB] = largest_packet_bits_q;
            rdata_d[`UFRH_TOGGLE_BIT] = interval_toggle_q;
        end else if (addr_is(paddr, `UFRH_OFF_COUNTDOWN)) begin
            rdata_d[`UFRH_FI_MSB:0] = countdown_value;
            rdata_d[`UFRH_TOGGLE_BIT] = countdown_toggle;
        end else if (addr_is(paddr, `UFRH_OFF_FRAMENUM)) begin
            rdata_d[`UFRH_FN_MSB:0] = frame_count;
        end else if (addr_is(paddr, `UFRH_OFF_PERIODIC)) begin
            rdata_d[`UFRH_PS_MSB:0] = periodic_start_value_q;
        end else if (addr_is(paddr, `UFRH_OFF_LSCUT)) begin
            rdata_d[`UFRH_LST_MSB:0] = low_speed_cutoff_q;
        end else if (addr_is(paddr, `UFRH_OFF_DESC_A)) begin
            rdata_d[`UFRH_PCNT_MSB:0] = port_count_q;
            rdata_d[`UFRH_PGRP_BIT]   = power_grouping_select_q;
            rdata_d[`UFRH_APWR_BIT]   = always_powered_q;
            rdata_d[`UFRH_DTYP_BIT]   = 1'b0;
            rdata_d[`UFRH_OCGRP_BIT]  = overcurrent_grouping_q;
            rdata_d[`UFRH_OCABS_BIT]  = overcurrent_absent_q;
            rdata_d[`UFRH_PSW_MSB:`UFRH_PSW_LSB] = power_settle_wait_q;
        end else if (addr_is(paddr, `UFRH_OFF_DESC_B)) begin
            rdata_d[`UFRH_RMV_MSB:1] = removable_q;
            rdata_d[`UFRH_PPM_MSB:`UFRH_PPM_LSB+1] = mask_q;
        end else begin
            hit_d = 1'b0;
        end
    end

    // APB answer: pready rises one cycle into the access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (access && !pready) begin
            pready  <= 1'b1;
            pslverr <= !hit_d;
            prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Frame timing settings; the controller-level reset clears them too.
    // The driver must flip the toggle with each new interval, so the
    // written toggle is stored as given and never changed here.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_interval_q       <= `UFRH_RST_INTERVAL;
            largest_packet_bits_q  <= `UFRH_RST_LPB;
            interval_toggle_q      <= 1'b0;
            periodic_start_value_q <= `UFRH_RST_PERIODIC;
            low_speed_cutoff_q     <= `UFRH_RST_LSCUT;
        end else if (soft_reset) begin
            frame_interval_q       <= `UFRH_RST_INTERVAL;
            largest_packet_bits_q  <= `UFRH_RST_LPB;
            interval_toggle_q      <= 1'b0;
            periodic_start_value_q <= `UFRH_RST_PERIODIC;
            low_speed_cutoff_q     <= `UFRH_RST_LSCUT;
        end else if (wr_en && !pslverr) begin
            if (addr_is(paddr, `UFRH_OFF_INTERVAL)) begin
                frame_interval_q <= pwdata[`UFRH_FI_MSB:0];
                largest_packet_bits_q <=
                    pwdata[`UFRH_LPB_MSB:`UFRH_LPB_LSB];
                interval_toggle_q <= pwdata[`UFRH_TOGGLE_BIT];
            end
            if (addr_is(paddr, `UFRH_OFF_PERIODIC)) begin
                periodic_start_value_q <= pwdata[`UFRH_PS_MSB:0];
            end
            if (addr_is(paddr, `UFRH_OFF_LSCUT)) begin
                low_speed_cutoff_q <= pwdata[`UFRH_LST_MSB:0];
            end
        end
    end

    // Descriptor A fields. Only presetn restores them; soft_reset is not
    // looked at, so a controller reset keeps the driver's hub setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_grouping_select_q <= `UFRH_RST_PGRP;
            always_powered_q        <= `UFRH_RST_APWR;
            overcurrent_grouping_q  <= `UFRH_RST_OCGRP;
            overcurrent_absent_q    <= `UFRH_RST_OCABS;
            power_settle_wait_q     <= `UFRH_RST_PSW;
        end else if (wr_en && addr_is(paddr, `UFRH_OFF_DESC_A)) begin
            power_grouping_select_q <= pwdata[`UFRH_PGRP_BIT];
            always_powered_q        <= pwdata[`UFRH_APWR_BIT];
            overcurrent_grouping_q  <= pwdata[`UFRH_OCGRP_BIT];
            overcurrent_absent_q    <= pwdata[`UFRH_OCABS_BIT];
            power_settle_wait_q     <=
                pwdata[`UFRH_PSW_MSB:`UFRH_PSW_LSB];
        end
    end

    // Descriptor B fields. The mask default depends on the strap, which a
    // reset flop may not take, so it is caught once the strap has settled.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            removable_q <= `UFRH_RST_RMV;
            mask_q      <= 3'h0;
        end else if (strap_wait_q == `UFRH_STRAP_WAIT) begin
            mask_q <= mask_default_of(strap_s2_q[2:0], strap_s2_q[3]);
        end else if (wr_en && addr_is(paddr, `UFRH_OFF_DESC_B)) begin
            removable_q <= pwdata[`UFRH_RMV_MSB:1];
            mask_q      <= pwdata[`UFRH_PPM_MSB:`UFRH_PPM_LSB+1];
        end
    end

    // Frame countdown, toggle copy and frame number.
    ufrh_frame_timer u_timer (
        .pclk          (pclk),
        .presetn       (presetn),
        .soft_clr      (soft_reset),
        .run           (frame_run),
        .interval      (frame_interval_q),
        .int_toggle    (interval_toggle_q),
        .countdown_q   (countdown_value),
        .cd_toggle_q   (countdown_toggle),
        .frame_count_q (frame_count),
        .frame_start_q (frame_start)
    );

    // Frame status for the list scheduler, all registered. Periodic work
    // opens once the countdown falls to the start value; a low-speed packet
    // may start only while more than the cutoff remains, which keeps it off
    // the end-of-frame guard.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_q             <= 1'b0;
            periodic_active_q <= 1'b0;
            low_speed_ok_q    <= 1'b0;
        end else begin
            sof_q <= frame_start;
            periodic_active_q <= frame_run &&
                (countdown_value <= periodic_start_value_q);
            low_speed_ok_q <= frame_run &&
                (countdown_value > {2'b00, low_speed_cutoff_q});
        end
    end

    // Descriptor fields offered to the port logic, reserved bits at zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_count_q       <= 8'h00;
            removable_flags_q  <= 4'h0;
            port_power_masks_q <= 4'h0;
        end else begin
            port_count_q <=
                port_count_of(strap_s2_q[2:0], strap_s2_q[3]);
            removable_flags_q  <= {removable_q, 1'b0};
            port_power_masks_q <= {mask_q, 1'b0};
        end
    end

endmodule

// file: ufrh_strap_model.sv
// Board-side strap source that sets the port layout of the root hub.
`timescale 1ns/1ps

module ufrh_strap_model (
    input  logic       pclk,
    input  logic [2:0] cfg_sel,
    input  logic       func_sel,
    output logic [2:0] port_config_register,
    output logic       second_function
);
    // Start at a legal layout so the design never sees an unknown strap.
    initial begin
        port_config_register = 3'h5;
        second_function      = 1'b0;
    end

    // Straps move only on a clock edge, like a board jumper read by firmware.
    always @(posedge pclk) begin
        port_config_register <= cfg_sel;
        second_function      <= func_sel;
    end
endmodule

// file: ufrh_chk.sv
// Port-level assertions of the frame timing and root hub register block.
`timescale 1ns/1ps

module ufrh_chk (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        soft_reset,
    input logic        frame_run,
    input logic [2:0]  port_config_register,
    input logic        second_function,
    input logic        periodic_active_q,
    input logic        low_speed_ok_q,
    input logic [7:0]  port_count_q,
    input logic        power_grouping_select_q,
    input logic        always_powered_q,
    input logic        overcurrent_grouping_q,
    input logic        overcurrent_absent_q,
    input logic [3:0]  removable_flags_q,
    input logic [3:0]  port_power_masks_q
);
    // Port count per strap value; unknown straps fall back to one port.
    function automatic logic [7:0] exp_cnt(input logic [2:0] c,
                                           input logic f);
        case (c)
            3'h5: exp_cnt = f ? 8'h02 : 8'h03;
            3'h4: exp_cnt = 8'h02;
            3'h3: exp_cnt = f ? 8'h01 : 8'h02;
            default: exp_cnt = 8'h01;
        endcase
    endfunction

    // A completed read, taken at the edge the master samples pready.
    wire rd_done = psel && penable && pready && !pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dtype_zero: assert property (
        rd_done && paddr == 8'h48 |-> !prdata[10])
        else $error("device type bit read as one");
    a_cd_rsvd: assert property (
        rd_done && paddr == 8'h38 |-> prdata[30:14] == 17'h00000)
        else $error("countdown reserved bits not zero");
    a_fn_rsvd: assert property (
        rd_done && paddr == 8'h3C |-> prdata[31:16] == 16'h0000)
        else $error("frame number reserved bits not zero");
    a_desc_outs: assert property (
        rd_done && paddr == 8'h48 |-> prdata[8] == power_grouping_select_q
        && prdata[9] == always_powered_q && prdata[12] == overcurrent_absent_q
        && prdata[11] == overcurrent_grouping_q)
        else $error("descriptor read disagrees with its outputs");
    a_rmv_bit0: assert property (
        rd_done && paddr == 8'h4C |-> prdata[3:0] == removable_flags_q
        && !removable_flags_q[0])
        else $error("removable flags wrong or bit 0 set");
    a_ppm_bit0: assert property (
        rd_done && paddr == 8'h4C |-> prdata[19:16] == port_power_masks_q
        && !port_power_masks_q[0])
        else $error("power masks wrong or bit 0 set");
    a_per_run: assert property (periodic_active_q |-> $past(frame_run))
        else $error("periodic service active while stopped");
    a_ls_run: assert property (low_speed_ok_q |-> $past(frame_run))
        else $error("low speed start allowed while stopped");
    a_soft_keep: assert property (
        soft_reset && !psel && !$past(psel) |=> $stable({
        power_grouping_select_q, always_powered_q, overcurrent_grouping_q,
        overcurrent_absent_q, removable_flags_q}))
        else $error("controller reset changed descriptor fields");
    a_port_cnt: assert property (
        $stable({port_config_register, second_function})[*5]
        |-> port_count_q == exp_cnt(port_config_register, second_function))
        else $error("port count does not follow strap");

    c_desc_read: cover property (rd_done && paddr == 8'h48);
    c_err_read: cover property (rd_done && paddr == 8'h50);
    c_periodic: cover property (periodic_active_q && low_speed_ok_q);
endmodule

bind ufrh_top ufrh_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .soft_reset, .frame_run, .port_config_register,
    .second_function, .periodic_active_q, .low_speed_ok_q, .port_count_q,
    .power_grouping_select_q, .always_powered_q, .overcurrent_grouping_q,
    .overcurrent_absent_q, .removable_flags_q, .port_power_masks_q);

// file: ufrh_tb_top.sv
// Self-checking bench of the frame timing and root hub register block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module ufrh_tb_top;
    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic        soft_reset = 1'b0;
    logic        frame_run = 1'b0;
    logic [2:0]  cfg_sel = 3'h5;
    logic        func_sel = 1'b0;
    wire  [2:0]  port_config_register;
    wire         second_function;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         sof_q;
    wire         periodic_active_q;
    wire         low_speed_ok_q;
    wire  [7:0]  port_count_q;
    wire         power_grouping_select_q;
    wire         always_powered_q;
    wire         overcurrent_grouping_q;
    wire         overcurrent_absent_q;
    wire  [3:0]  removable_flags_q;
    wire  [3:0]  port_power_masks_q;
    int          num_errors = 0;
    int          n_checks = 0;

    ufrh_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .soft_reset, .frame_run,
        .port_config_register, .second_function, .sof_q,
        .periodic_active_q, .low_speed_ok_q, .port_count_q,
        .power_grouping_select_q, .always_powered_q, .overcurrent_grouping_q,
        .overcurrent_absent_q, .removable_flags_q, .port_power_masks_q);
    ufrh_strap_model straps (.pclk, .cfg_sel, .func_sel,
        .port_config_register, .second_function);

    // Expected port count and power mask default for a strap setting.
    function automatic logic [7:0] exp_cnt(input int c, input logic f);
        if (c == 5) return f ? 8'h02 : 8'h03;
        if (c == 3) return f ? 8'h01 : 8'h02;
        return (c == 4) ? 8'h02 : 8'h01;
    endfunction
    function automatic logic [3:0] exp_ppm(input int c, input logic f);
        if (c == 5) return f ? 4'h6 : 4'hE;
        if (c == 3) return f ? 4'h2 : 4'h6;
        return (c == 4) ? 4'h6 : 4'h2;
    endfunction

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until pready is seen high or 50 edges pass.
    // A spare edge at the end keeps two calls from colliding in one step.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [32:0] res);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        res = {pslverr, prdata};
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50) num_errors++;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic er, input string nm);
        logic [32:0] r;
        apb(1'b0, a, 32'h00000000, r);
        `CHK(nm, {er, e}, r)
    endtask

    task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                        input logic er);
        logic [32:0] r;
        apb(1'b1, a, d, r);
        `CHK("write response", er, r[32])
    endtask

    task automatic hw_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
    endtask

    // The full frame is far longer than the run allows, so the reload and
    // toggle copy are left to review; only the first ticks are timed here.
    initial begin
        int c;
        logic f;
        hw_reset();
        rchk(8'h34, 32'h00002EDF, 1'b0, "interval");
        rchk(8'h38, 32'h00002EDF, 1'b0, "countdown");
        rchk(8'h3C, 32'h00000000, 1'b0, "frame number");
        rchk(8'h40, 32'h00000000, 1'b0, "periodic start");
        rchk(8'h44, 32'h00000628, 1'b0, "low speed cutoff");
        `CHK("desc a outs", 8'hA0, {power_grouping_select_q, always_powered_q,
            overcurrent_grouping_q, overcurrent_absent_q, removable_flags_q})
        for (int i = 0; i < 8; i++) begin
            c = 5 - i / 2;
            f = i[0];
            cfg_sel  <= c[2:0];
            func_sel <= f;
            hw_reset();
            rchk(8'h48, {24'h0F0009, exp_cnt(c, f)}, 1'b0, "desc a");
            rchk(8'h4C, {12'h000, exp_ppm(c, f), 16'h0000}, 1'b0, "desc b");
            `CHK("masks out", exp_ppm(c, f), port_power_masks_q)
        end
        wchk(8'h34, 32'hFFFFFFFF, 1'b0);
        rchk(8'h34, 32'hFFFF3FFF, 1'b0, "interval all");
        wchk(8'h34, 32'h00000005, 1'b0);
        rchk(8'h34, 32'h00000005, 1'b0, "interval toggled");
        wchk(8'h40, 32'hFFFFFFFF, 1'b0);
        rchk(8'h40, 32'h00003FFF, 1'b0, "periodic all");
        wchk(8'h44, 32'hFFFFFFFF, 1'b0);
        rchk(8'h44, 32'h00000FFF, 1'b0, "cutoff all");
        wchk(8'h48, 32'hFFFFFFFF, 1'b0);
        rchk(8'h48, 32'hFF001B01, 1'b0, "desc a all");
        wchk(8'h4C, 32'hFFFFFFFF, 1'b0);
        rchk(8'h4C, 32'h000E000E, 1'b0, "desc b all");
        `CHK("desc outs", 8'hFE, {power_grouping_select_q, always_powered_q,
            overcurrent_grouping_q, overcurrent_absent_q, removable_flags_q})
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        @(posedge pclk);
        rchk(8'h48, 32'hFF001B01, 1'b0, "desc a kept");
        rchk(8'h4C, 32'h000E000E, 1'b0, "desc b kept");
        wchk(8'h38, 32'h00000000, 1'b0);
        rchk(8'h38, 32'h00002EDF, 1'b0, "countdown ro");
        wchk(8'h3C, 32'hFFFFFFFF, 1'b0);
        rchk(8'h3C, 32'h00000000, 1'b0, "frame number ro");
        wchk(8'h50, 32'hFFFFFFFF, 1'b1);
        rchk(8'h50, 32'h00000000, 1'b1, "unmapped");
        wchk(8'h40, 32'h00002ED8, 1'b0);
        wchk(8'h44, 32'h00000628, 1'b0);
        // 200 running edges give exactly 12 bit-time ticks.
        frame_run <= 1'b1;
        repeat (20) @(posedge pclk);
        `CHK("periodic early", 1'b0, periodic_active_q)
        `CHK("low speed ok", 1'b1, low_speed_ok_q)
        repeat (180) @(posedge pclk);
        `CHK("periodic late", 1'b1, periodic_active_q)
        `CHK("no reload yet", 1'b0, sof_q)
        frame_run <= 1'b0;
        rchk(8'h38, 32'h00002ED3, 1'b0, "countdown run");
        rchk(8'h3C, 32'h00000000, 1'b0, "frame number run");
        end_of_test();
    end

    // A run still going at 100000 ns ends as a failure.
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule
